//--- sub_mul_pkg.sv
package sub_mul_pkg;
  // ----------------------------------------
  // word and field widths
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam int ADDR_W = 15;
  localparam int OP_W = 6;
  localparam int MOD_W = 3;
  localparam int IDX_W = 2;
  localparam int TIME_W = 12;
  localparam int REPEAT_W = 15;

  // ----------------------------------------
  // operation codes (octal 57 and 60)
  // ----------------------------------------
  localparam logic [OP_W-1:0] OP_REPLACE_SUBSTITUTE_BITS = 6'h2F;
  localparam logic [OP_W-1:0] OP_MULTIPLY_STEP = 6'h30;

  // ----------------------------------------
  // word-portion designator codes
  // ----------------------------------------
  localparam logic [MOD_W-1:0] MOD_FULL = 3'h0;
  localparam logic [MOD_W-1:0] MOD_LOW_HALF = 3'h1;
  localparam logic [MOD_W-1:0] MOD_HIGH_HALF = 3'h2;
  localparam logic [MOD_W-1:0] MOD_ADDR_PART = 3'h3;
  localparam logic [WORD_W-1:0] MASK_FULL = 24'hFFFFFF;
  localparam logic [WORD_W-1:0] MASK_LOW_HALF = 24'h000FFF;
  localparam logic [WORD_W-1:0] MASK_HIGH_HALF = 24'hFFF000;
  localparam logic [WORD_W-1:0] MASK_ADDR_PART = 24'h007FFF;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [WORD_W-1:0] ACC_RESET = 24'h000000;
  localparam logic [WORD_W-1:0] Q_RESET = 24'h000000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MERGE_SINGLE_US = 60;
  localparam int MERGE_REPEAT_US = 40;
  localparam int MUL_EVEN_SINGLE_US = 28;
  localparam int MUL_EVEN_REPEAT_US = 8;
  localparam int MUL_ODD_SINGLE_US = 52;
  localparam int MUL_ODD_REPEAT_US = 32;

  function automatic logic [TIME_W-1:0] us_to_cycles(input int us);
    us_to_cycles = TIME_W'((us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  localparam logic [TIME_W-1:0] MERGE_SINGLE_CYC = us_to_cycles(MERGE_SINGLE_US);
  localparam logic [TIME_W-1:0] MERGE_REPEAT_CYC = us_to_cycles(MERGE_REPEAT_US);
  localparam logic [TIME_W-1:0] MUL_EVEN_SINGLE_CYC = us_to_cycles(MUL_EVEN_SINGLE_US);
  localparam logic [TIME_W-1:0] MUL_EVEN_REPEAT_CYC = us_to_cycles(MUL_EVEN_REPEAT_US);
  localparam logic [TIME_W-1:0] MUL_ODD_SINGLE_CYC = us_to_cycles(MUL_ODD_SINGLE_US);
  localparam logic [TIME_W-1:0] MUL_ODD_REPEAT_CYC = us_to_cycles(MUL_ODD_REPEAT_US);

  function automatic logic [WORD_W-1:0] portion_mask(input logic [MOD_W-1:0] m);
    unique case (m)
      MOD_LOW_HALF: portion_mask = MASK_LOW_HALF;
      MOD_HIGH_HALF: portion_mask = MASK_HIGH_HALF;
      MOD_ADDR_PART: portion_mask = MASK_ADDR_PART;
      default: portion_mask = MASK_FULL;
    endcase
  endfunction
endpackage

//--- sub_mul_alu.sv
`timescale 1ns/10ps
module sub_mul_alu
  import sub_mul_pkg::*;
(
  input wire logic i_is_mul,
  input wire logic [WORD_W-1:0] i_acc,
  input wire logic [WORD_W-1:0] i_q,
  input wire logic [WORD_W-1:0] i_operand,
  input wire logic [WORD_W-1:0] i_portion,
  output logic [WORD_W-1:0] o_acc_next,
  output logic [WORD_W-1:0] o_q_next
);
  // ----------------------------------------
  // merge and multiply step
  // ----------------------------------------
  wire [WORD_W-1:0] y_eff = i_operand & i_portion;
  wire [WORD_W-1:0] sel = i_q & i_portion;
  wire [WORD_W-1:0] merged = (y_eff & sel) | (i_acc & ~sel);
  // unsigned add, carry kept so it shifts into the top of A
  wire [WORD_W:0] addend = i_q[0] ? {1'b0, y_eff} : '0;
  wire [WORD_W:0] sum = {1'b0, i_acc} + addend;
  assign o_acc_next = i_is_mul ? sum[WORD_W:1] : merged;
  assign o_q_next = i_is_mul ? {sum[0], i_q[WORD_W-1:1]} : i_q;
endmodule

//--- sub_mul_step.sv
`timescale 1ns/10ps
// Function
// - opcode 57 copies operand bits into A where Q mask bit is one.
// - merged A is written back to the operand's storage location.
// - Q is left untouched by the merge instruction.
// - operand address is low 15 instruction bits plus selected index.
// - merge takes 60 us singly, 40 us each when repeated.
// - both support repeat, index designator and word-portion modifier.
// - opcode 60 adds operand to A when Q bit 0 is one.
// - multiply step leaves A unchanged when Q bit 0 is zero.
// - then A and Q shift right together, A bit 0 into Q bit 23.
// - after 24 steps product low half in Q, high half in A.
// - a nonzero starting A is accumulated onto, not cleared.
// - operands are unsigned magnitudes.
// - even step takes 28 us singly, 8 us repeated.
// - odd step takes 52 us singly, 32 us repeated.
module sub_mul_step
  import sub_mul_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [OP_W-1:0] i_opcode,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic [IDX_W-1:0] i_index_sel,
  input wire logic [ADDR_W-1:0] i_index1,
  input wire logic [ADDR_W-1:0] i_index2,
  input wire logic [ADDR_W-1:0] i_index3,
  input wire logic [MOD_W-1:0] i_modifier,
  input wire logic [REPEAT_W-1:0] i_repeat_count,
  input wire logic i_acc_load,
  input wire logic [WORD_W-1:0] i_acc_value,
  input wire logic i_q_load,
  input wire logic [WORD_W-1:0] i_q_value,
  input wire logic i_mem_rvalid,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [WORD_W-1:0] o_mem_wdata,
  output logic [WORD_W-1:0] o_acc,
  output logic [WORD_W-1:0] o_q,
  output logic o_busy,
  output logic o_done
);
  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_EXEC = 3'b010,
    ST_HOLD = 3'b011
  } step_state_e;

  step_state_e state_reg, state_next;
  logic [WORD_W-1:0] acc_reg, acc_next;
  logic [WORD_W-1:0] q_reg, q_next;
  logic [WORD_W-1:0] operand_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [MOD_W-1:0] mod_reg;
  logic is_mul_reg;
  logic repeat_reg;
  logic [REPEAT_W-1:0] remaining_reg;
  logic [TIME_W-1:0] timer_reg;
  logic [TIME_W-1:0] target_reg;
  logic rd_reg;
  logic wr_reg;
  logic [WORD_W-1:0] wdata_reg;
  logic done_reg;

  function automatic logic [ADDR_W-1:0] index_value(input logic [IDX_W-1:0] s,
      input logic [ADDR_W-1:0] b1, input logic [ADDR_W-1:0] b2,
      input logic [ADDR_W-1:0] b3);
    unique case (s)
      2'h1: index_value = b1;
      2'h2: index_value = b2;
      2'h3: index_value = b3;
      default: index_value = '0;
    endcase
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire op_merge = i_opcode == OP_REPLACE_SUBSTITUTE_BITS;
  wire op_mul = i_opcode == OP_MULTIPLY_STEP;
  wire accept = (state_reg == ST_IDLE) && i_start && (op_merge || op_mul);
  // repeat passes reuse one address, so each merge pass rewrites the same word
  wire [ADDR_W-1:0] eff_addr = ADDR_W'(i_address + index_value(i_index_sel, i_index1,
      i_index2, i_index3));
  wire [WORD_W-1:0] cur_mask = portion_mask(mod_reg);
  wire time_up = timer_reg >= target_reg - TIME_W'(1);
  wire last_exec = remaining_reg == REPEAT_W'(1);
  wire in_exec = state_reg == ST_EXEC;
  // odd/even timing is decided by Q bit 0 before the shift
  wire [TIME_W-1:0] mul_cycles = q_reg[0] ?
      (repeat_reg ? MUL_ODD_REPEAT_CYC : MUL_ODD_SINGLE_CYC) :
      (repeat_reg ? MUL_EVEN_REPEAT_CYC : MUL_EVEN_SINGLE_CYC);
  wire [TIME_W-1:0] merge_cycles = repeat_reg ? MERGE_REPEAT_CYC : MERGE_SINGLE_CYC;
  wire [WORD_W-1:0] alu_acc;
  wire [WORD_W-1:0] alu_q;

  sub_mul_alu sub_mul_alu_i (
    .i_is_mul(is_mul_reg),
    .i_acc(acc_reg),
    .i_q(q_reg),
    .i_operand(operand_reg),
    .i_portion(cur_mask),
    .o_acc_next(alu_acc),
    .o_q_next(alu_q)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (i_mem_rvalid) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: state_next = ST_HOLD;
      ST_HOLD: begin
        if (time_up) begin
          state_next = last_exec ? ST_IDLE : ST_READ;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // loads from the controller only land while idle
  always_comb begin
    acc_next = acc_reg;
    q_next = q_reg;
    if (in_exec) begin
      acc_next = alu_acc;
      q_next = alu_q;
    end else if (state_reg == ST_IDLE) begin
      if (i_acc_load) begin
        acc_next = i_acc_value;
      end
      if (i_q_load) begin
        q_next = i_q_value;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      acc_reg <= ACC_RESET;
      q_reg <= Q_RESET;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      q_reg <= q_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_reg <= '0;
      mod_reg <= MOD_FULL;
      is_mul_reg <= 1'b0;
      repeat_reg <= 1'b0;
      remaining_reg <= '0;
    end else if (accept) begin
      addr_reg <= eff_addr;
      mod_reg <= i_modifier;
      is_mul_reg <= op_mul;
      repeat_reg <= i_repeat_count != '0;
      remaining_reg <= (i_repeat_count == '0) ? REPEAT_W'(1) : i_repeat_count;
    end else if (state_reg == ST_HOLD && time_up && !last_exec) begin
      remaining_reg <= remaining_reg - REPEAT_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      operand_reg <= '0;
      target_reg <= '0;
    end else if (state_reg == ST_READ && i_mem_rvalid) begin
      operand_reg <= i_mem_rdata;
    end else if (in_exec) begin
      target_reg <= is_mul_reg ? mul_cycles : merge_cycles;
    end
  end

  // timer runs from the read request of each execution
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_reg <= '0;
    end else if (state_next == ST_READ && state_reg != ST_READ) begin
      timer_reg <= '0;
    end else if (state_reg != ST_IDLE) begin
      timer_reg <= timer_reg + TIME_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      rd_reg <= state_next == ST_READ && state_reg != ST_READ;
      wr_reg <= in_exec && !is_mul_reg;
      if (in_exec) begin
        wdata_reg <= alu_acc;
      end
      done_reg <= state_reg == ST_HOLD && time_up && last_exec;
    end
  end

  assign o_mem_rd = rd_reg;
  assign o_mem_wr = wr_reg;
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_acc = acc_reg;
  assign o_q = q_reg;
  assign o_busy = state_reg != ST_IDLE;
  assign o_done = done_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  merge_result_a: assert property (in_exec && !is_mul_reg |=> acc_reg ==
      (($past(operand_reg) & $past(q_reg) & $past(cur_mask)) |
      ($past(acc_reg) & ~($past(q_reg) & $past(cur_mask)))))
    else $error("merge result wrong");
  merge_writeback_a: assert property (o_mem_wr |-> o_mem_wdata == acc_reg &&
      o_mem_addr == addr_reg)
    else $error("write back wrong");
  mask_kept_a: assert property (in_exec && !is_mul_reg |=> $stable(q_reg))
    else $error("mask register changed");
  addr_form_a: assert property (accept |-> ##1 o_mem_rd ##0 o_mem_addr ==
      ADDR_W'($past(i_address) + index_value($past(i_index_sel), $past(i_index1),
      $past(i_index2), $past(i_index3))))
    else $error("operand address wrong");
  merge_time_a: assert property (in_exec && !is_mul_reg |=> target_reg ==
      (repeat_reg ? MERGE_REPEAT_CYC : MERGE_SINGLE_CYC))
    else $error("merge time wrong");
  mul_add_a: assert property (in_exec && is_mul_reg && q_reg[0] |=>
      {acc_reg, q_reg[WORD_W-1]} == {1'b0, $past(acc_reg)} +
      {1'b0, $past(operand_reg) & $past(cur_mask)})
    else $error("multiply add wrong");
  mul_even_a: assert property (in_exec && is_mul_reg && !q_reg[0] |=>
      {acc_reg, q_reg[WORD_W-1]} == {1'b0, $past(acc_reg)})
    else $error("even step changed A");
  mul_shift_a: assert property (in_exec && is_mul_reg |=>
      q_reg[WORD_W-2:0] == $past(q_reg[WORD_W-1:1]))
    else $error("shift wrong");
  mul_time_a: assert property (in_exec && is_mul_reg |=> target_reg ==
      ($past(q_reg[0]) ? (repeat_reg ? MUL_ODD_REPEAT_CYC : MUL_ODD_SINGLE_CYC) :
      (repeat_reg ? MUL_EVEN_REPEAT_CYC : MUL_EVEN_SINGLE_CYC)))
    else $error("multiply time wrong");
  done_end_a: assert property (state_reg == ST_HOLD && time_up && last_exec
      |=> o_done && !o_busy)
    else $error("done missing");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  repeat_next_a: assert property (state_reg == ST_HOLD && time_up && !last_exec
      |=> o_mem_rd && remaining_reg == $past(remaining_reg) - REPEAT_W'(1))
    else $error("repeat did not restart");
  rd_pulse_a: assert property (o_mem_rd |=> !o_mem_rd)
    else $error("read request longer than one cycle");
  addr_kept_a: assert property (o_busy |=> $stable(o_mem_addr))
    else $error("operand address moved mid instruction");
  wr_merge_only_a: assert property (o_mem_wr |-> !is_mul_reg)
    else $error("write back from a multiply step");
  idle_no_write_a: assert property (!o_busy |-> !o_mem_wr)
    else $error("write while idle");
  // loads are refused while busy, so A and Q move only in the step cycle
  q_hold_a: assert property (o_busy && !in_exec |=> $stable(q_reg))
    else $error("Q moved outside a step");
  acc_hold_a: assert property (o_busy && !in_exec |=> $stable(acc_reg))
    else $error("A moved outside a step");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  merge_single_c: cover property (in_exec && !is_mul_reg && !repeat_reg ##1 o_mem_wr);
  merge_repeat_c: cover property (o_mem_wr && repeat_reg);
  mul_odd_c: cover property (in_exec && is_mul_reg && q_reg[0] && repeat_reg);
  mul_even_c: cover property (in_exec && is_mul_reg && !q_reg[0] && !repeat_reg);
  repeat_done_c: cover property (o_done && repeat_reg);
endmodule

//--- operand_store.sv
`timescale 1ns/10ps
module operand_store
  import sub_mul_pkg::*;
#(
  parameter int LAT = 2
)(
  input wire logic i_mclk,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [ADDR_W-1:0] i_mem_addr,
  input wire logic [WORD_W-1:0] i_mem_wdata,
  output logic o_mem_rvalid,
  output logic [WORD_W-1:0] o_mem_rdata
);
  logic [WORD_W-1:0] words [0:(1<<ADDR_W)-1];
  logic [LAT-1:0] pend_reg = '0;
  logic [ADDR_W-1:0] addr_reg = '0;
  logic [WORD_W-1:0] last_reg = '0;
  int writes = 0;
  // ----------------------------------------
  // read answer after LAT cycles, write taken at once
  // ----------------------------------------
  always @(posedge i_mclk) begin
    pend_reg <= {pend_reg[LAT-2:0], i_mem_rd};
    if (i_mem_rd) begin
      addr_reg <= i_mem_addr;
    end
    if (o_mem_rvalid) begin
      last_reg <= o_mem_rdata;
    end
    if (i_mem_wr) begin
      words[i_mem_addr] <= i_mem_wdata;
      writes <= writes + 1;
    end
  end
  assign o_mem_rvalid = pend_reg[LAT-1];
  // released data lines show the inverse, so a late sample cannot pass by luck
  assign o_mem_rdata = o_mem_rvalid ? words[addr_reg] : ~last_reg;
endmodule

//--- sub_mul_step_test.sv
`timescale 1ns/10ps
`define check_eq(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  failures++; $display("unexpected %s: expected %h, seen %h", name, exp, got); end end
module sub_mul_step_test;
  import sub_mul_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_start = 1'b0;
  logic i_acc_load = 1'b0;
  logic i_q_load = 1'b0;
  logic [OP_W-1:0] i_opcode = '0;
  logic [ADDR_W-1:0] i_address = '0;
  logic [IDX_W-1:0] i_index_sel = '0;
  logic [MOD_W-1:0] i_modifier = '0;
  logic [REPEAT_W-1:0] i_repeat_count = '0;
  logic [WORD_W-1:0] i_acc_value = '0;
  logic [WORD_W-1:0] i_q_value = '0;
  logic [WORD_W-1:0] i_mem_rdata, o_mem_wdata, o_acc, o_q;
  logic i_mem_rvalid, o_mem_rd, o_mem_wr, o_busy, o_done;
  logic [ADDR_W-1:0] o_mem_addr;
  int failures = 0;
  int samples_checked = 0;
  always #(CLK_PERIOD_NS / 2) i_mclk = ~i_mclk;
  sub_mul_step sub_mul_step_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_start(i_start),
    .i_opcode(i_opcode), .i_address(i_address), .i_index_sel(i_index_sel),
    .i_index1(15'h0023), .i_index2(15'h0005), .i_index3(15'h7FF0), .i_modifier(i_modifier),
    .i_repeat_count(i_repeat_count), .i_acc_load(i_acc_load), .i_acc_value(i_acc_value),
    .i_q_load(i_q_load), .i_q_value(i_q_value), .i_mem_rvalid(i_mem_rvalid),
    .i_mem_rdata(i_mem_rdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_q(o_q),
    .o_busy(o_busy), .o_done(o_done));
  operand_store operand_store_i (.i_mclk(i_mclk), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_rvalid(i_mem_rvalid),
    .o_mem_rdata(i_mem_rdata));
  // ----------------------------------------
  // shared drivers
  // ----------------------------------------
  task automatic load(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] q);
    @(posedge i_mclk);
    i_acc_load <= 1'b1;
    i_acc_value <= a;
    i_q_load <= 1'b1;
    i_q_value <= q;
    @(posedge i_mclk);
    i_acc_load <= 1'b0;
    i_q_load <= 1'b0;
  endtask
  // cycles from first read request to done; a start and loads while busy must be ignored
  task automatic run(input logic [OP_W-1:0] op, input logic [ADDR_W-1:0] a,
      input logic [IDX_W-1:0] b, input logic [MOD_W-1:0] m, input logic [REPEAT_W-1:0] n,
      output int cyc);
    int t0;
    int k;
    t0 = -1;
    @(posedge i_mclk);
    i_opcode <= op;
    i_address <= a;
    i_index_sel <= b;
    i_modifier <= m;
    i_repeat_count <= n;
    i_start <= 1'b1;
    @(posedge i_mclk);
    i_start <= 1'b0;
    for (k = 0; k < 20000; k++) begin
      #1;
      if (o_mem_rd === 1'b1 && t0 < 0) t0 = k;
      if (k == 0) `check_eq("busy", 1'b1, o_busy)
      if (o_done === 1'b1) break;
      @(posedge i_mclk);
      i_start <= (k == 8);
      i_acc_load <= (k == 8);
      i_q_load <= (k == 8);
    end
    cyc = k - t0;
    `check_eq("idle at done", 1'b0, o_busy)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic merge_single();
    int cyc;
    int w0;
    logic [WORD_W-1:0] e;
    e = (24'h123456 & ~24'h0F0F0F) | (24'hABCDEF & 24'h0F0F0F);
    operand_store_i.words[15'h0123] = 24'hABCDEF;
    w0 = operand_store_i.writes;
    load(24'h123456, 24'h0F0F0F);
    run(OP_REPLACE_SUBSTITUTE_BITS, 15'h0100, 2'h1, MOD_FULL, 15'h0000, cyc);
    `check_eq("merged acc", e, o_acc)
    `check_eq("stored word", e, operand_store_i.words[15'h0123])
    `check_eq("write count", 1, operand_store_i.writes - w0)
    `check_eq("mask kept", 24'h0F0F0F, o_q)
    `check_eq("address", 15'h0123, o_mem_addr)
    `check_eq("single time", 60 * 1000 / CLK_PERIOD_NS, cyc)
    e = (e & MASK_HIGH_HALF) | (24'h000777 & ~MASK_HIGH_HALF);
    load(24'h000777, 24'hFFFFFF);
    run(OP_REPLACE_SUBSTITUTE_BITS, 15'h0100, 2'h1, MOD_HIGH_HALF, 15'h0000, cyc);
    `check_eq("high half acc", e, o_acc)
    `check_eq("high half word", e, operand_store_i.words[15'h0123])
  endtask
  task automatic merge_repeat();
    int cyc;
    int w0;
    logic [WORD_W-1:0] e;
    e = (24'h123456 & ~MASK_LOW_HALF) | (24'hABCDEF & MASK_LOW_HALF);
    operand_store_i.words[15'h0010] = 24'hABCDEF;
    w0 = operand_store_i.writes;
    load(24'h123456, 24'hFFFFFF);
    run(OP_REPLACE_SUBSTITUTE_BITS, 15'h0020, 2'h3, MOD_LOW_HALF, 15'h0002, cyc);
    `check_eq("portion acc", e, o_acc)
    `check_eq("stored word", e, operand_store_i.words[15'h0010])
    `check_eq("write count", 2, operand_store_i.writes - w0)
    `check_eq("mask kept", 24'hFFFFFF, o_q)
    `check_eq("wrapped address", 15'h0010, o_mem_addr)
    `check_eq("repeat time", 2 * 40 * 1000 / CLK_PERIOD_NS, cyc)
  endtask
  task automatic product_steps();
    int cyc;
    int w0;
    int ones;
    logic [2*WORD_W-1:0] p;
    p = 48'h000000000007 + 48'h000000800005 * 48'h000000000ABC;
    ones = $countones(24'h800005);
    operand_store_i.words[15'h0021] = 24'h000ABC;
    w0 = operand_store_i.writes;
    load(24'h000007, 24'h800005);
    run(OP_MULTIPLY_STEP, 15'h0021, 2'h0, MOD_FULL, 15'h0018, cyc);
    `check_eq("product high", p[47:24], o_acc)
    `check_eq("product low", p[23:0], o_q)
    `check_eq("no writes", 0, operand_store_i.writes - w0)
    `check_eq("mul time", (ones * 32 + (24 - ones) * 8) * 1000 / CLK_PERIOD_NS, cyc)
  endtask
  task automatic single_steps();
    int cyc;
    logic [WORD_W:0] s;
    logic [2*WORD_W:0] r;
    load(24'h000011, 24'h000002);
    run(OP_MULTIPLY_STEP, 15'h0030, 2'h0, MOD_FULL, 15'h0000, cyc);
    `check_eq("even acc", 24'h000008, o_acc)
    `check_eq("even q", 24'h800001, o_q)
    `check_eq("even time", 28 * 1000 / CLK_PERIOD_NS, cyc)
    s = 25'h0FFFFFF + 25'(24'hFF0001 & MASK_ADDR_PART);
    r = {s, 24'h000003} >> 1;
    operand_store_i.words[15'h0045] = 24'hFF0001;
    load(24'hFFFFFF, 24'h000003);
    run(OP_MULTIPLY_STEP, 15'h0040, 2'h2, MOD_ADDR_PART, 15'h0000, cyc);
    `check_eq("odd acc", r[47:24], o_acc)
    `check_eq("odd q", r[23:0], o_q)
    `check_eq("odd address", 15'h0045, o_mem_addr)
    `check_eq("odd time", 52 * 1000 / CLK_PERIOD_NS, cyc)
  endtask
  task automatic bad_opcode();
    @(posedge i_mclk);
    i_opcode <= 6'h31;
    i_start <= 1'b1;
    @(posedge i_mclk);
    i_start <= 1'b0;
    #1;
    `check_eq("busy on bad opcode", 1'b0, o_busy)
    `check_eq("read on bad opcode", 1'b0, o_mem_rd)
  endtask
  // ----------------------------------------
  // verdict and sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_mclk);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    bad_opcode();
    merge_single();
    merge_repeat();
    product_steps();
    single_steps();
    give_verdict();
  end
endmodule
